//--- core/flash_sw_map.svh
`ifndef FLASH_SW_MAP_SVH
`define FLASH_SW_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_ADDR_LOW    12'h000
`define OFF_ADDR_HIGH   12'h004
`define OFF_DATA_LOW    12'h008
`define OFF_DATA_HIGH   12'h00c
`define OFF_CONTROL     12'h010
`define OFF_UNLOCK      12'h014
`define OFF_IRQ_STATUS  12'h018
`define OFF_IRQ_MASK    12'h01c

// ----------------------------------------
// control and interrupt bit positions
// ----------------------------------------
`define CTL_CFG         6
`define CTL_LATCH_ONLY  5
`define CTL_ERASE       4
`define CTL_ERR         3
`define CTL_EN          2
`define CTL_WR          1
`define CTL_RD          0
`define IRQ_DONE        0
`define IRQ_ERR         1

// ----------------------------------------
// values and timing
// ----------------------------------------
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'haa
`define CFG_ID_LAST     15'h0003
`define CFG_DEV_ID      15'h0006
`define CFG_WORD_LAST   15'h0008
`define ERASED_WORD     14'h3fff
`define PCLK_PERIOD_NS  50
`define PROG_TIME_NS    2000000
`define ERASE_TIME_NS   2000000
`define SLOT_CLOCKS     4
`define FORCED_NOPS     2
`define ROW_WORDS       16
`define WORD_BITS       14

`endif

//--- core/flash_sw_pkg.sv
package flash_sw_pkg;

    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_HALF = 3'b010,
        KEY_OPEN = 3'b100
    } key_state_t;

    typedef enum logic [3:0] {
        OP_IDLE   = 4'b0001,
        OP_NOPS   = 4'b0010,
        OP_TIMED  = 4'b0100,
        OP_FINISH = 4'b1000
    } op_state_t;

    typedef struct packed {
        logic cfg;
        logic latch_only;
        logic erase_sel;
        logic error;
        logic enable;
        logic wr;
        logic rd;
    } ctl_t;

endpackage : flash_sw_pkg

//--- core/flash_op_timer.sv
`timescale 1ns/1ps
`default_nettype none

module flash_op_timer #(
    parameter int CNT_W = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] load,
    output logic                  busy,
    output logic                  done
);

    logic [CNT_W-1:0] count;

    initial begin
        if (CNT_W < 2) begin
            $error("counter too narrow");
        end
    end

    // ----------------------------------------
    // self-timed countdown
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= load;
                busy  <= 1'b1;
            end else if (busy) begin
                if (count <= CNT_W'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - CNT_W'(1);
                end
            end
        end
    end

endmodule : flash_op_timer

`default_nettype wire

//--- core/flash_self_write.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_sw_map.svh"

module flash_self_write #(
    parameter int PROG_CYCLES  = (`PROG_TIME_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS,
    parameter int ERASE_CYCLES = (`ERASE_TIME_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic      [14:0] flash_addr,
    output logic             flash_cfg,
    input  wire logic [13:0] flash_rdata,
    output logic [`ROW_WORDS*`WORD_BITS-1:0] flash_row_data,
    output logic             flash_program,
    output logic             flash_erase,
    output logic             forced_nop,
    output logic             cpu_stall
);

    localparam int NOP_W = 2;

    initial begin
        if (PROG_CYCLES < 1 || ERASE_CYCLES < 1) begin
            $error("operation time must be at least one cycle");
        end
    end

    logic [7:0]                   addr_low;
    logic [6:0]                   addr_high;
    logic [7:0]                   data_low;
    logic [5:0]                   data_high;
    flash_sw_pkg::ctl_t           ctl;
    flash_sw_pkg::key_state_t     key_state;
    flash_sw_pkg::op_state_t      op_state;
    flash_sw_pkg::op_state_t      next_op_state;
    logic [1:0]                   irq_status;
    logic [1:0]                   irq_mask;
    logic [1:0]                   slot_cnt;
    logic [NOP_W-1:0]             nop_cnt;
    logic                         op_prog;
    logic [`WORD_BITS-1:0]        row [`ROW_WORDS];
    logic [7:0]                   read_val;
    logic                         hit;
    logic                         acc;
    logic                         wr_en;
    logic                         wr_attempt;
    logic                         start_ok;
    logic                         slot_tick;
    logic                         op_end;
    logic                         timer_start;
    logic                         timer_done;
    logic                         cfg_read_ok;
    logic                         cfg_write_ok;
    logic [14:0]                  word_addr;

    assign word_addr    = {addr_high, addr_low};
    assign acc          = psel & penable & pready;
    assign wr_en        = acc & pwrite;
    assign wr_attempt   = wr_en && paddr == `OFF_CONTROL && pwdata[`CTL_WR];
    assign cfg_read_ok  = word_addr <= `CFG_ID_LAST || word_addr == `CFG_DEV_ID
                          || (word_addr > `CFG_DEV_ID && word_addr <= `CFG_WORD_LAST);
    assign cfg_write_ok = !pwdata[`CTL_CFG] || word_addr <= `CFG_ID_LAST;
    assign start_ok     = wr_attempt && key_state == flash_sw_pkg::KEY_OPEN
                          && pwdata[`CTL_EN] && !ctl.wr && cfg_write_ok;
    assign slot_tick    = slot_cnt == 2'(`SLOT_CLOCKS - 1);
    assign op_end       = op_state == flash_sw_pkg::OP_FINISH;
    assign timer_start  = op_state == flash_sw_pkg::OP_NOPS
                          && next_op_state == flash_sw_pkg::OP_TIMED;

    // ----------------------------------------
    // apb read mux and slave answer
    // ----------------------------------------
    always_comb begin
        hit      = 1'b1;
        read_val = 8'h00;
        case (paddr)
            `OFF_ADDR_LOW:   read_val = addr_low;
            `OFF_ADDR_HIGH:  read_val = {1'b1, addr_high};
            `OFF_DATA_LOW:   read_val = data_low;
            `OFF_DATA_HIGH:  read_val = {2'b00, data_high};
            `OFF_CONTROL:    read_val = {1'b1, ctl};
            `OFF_UNLOCK:     read_val = 8'h00;
            `OFF_IRQ_STATUS: read_val = {6'h00, irq_status};
            `OFF_IRQ_MASK:   read_val = {6'h00, irq_mask};
            default:         hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= {24'h000000, read_val};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------
    // address and data registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_low  <= 8'h00;
            addr_high <= 7'h00;
        end else if (wr_en) begin
            if (paddr == `OFF_ADDR_LOW) begin
                addr_low <= pwdata[7:0];
            end
            if (paddr == `OFF_ADDR_HIGH) begin
                addr_high <= pwdata[6:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_low  <= 8'h00;
            data_high <= 6'h00;
        end else if (ctl.rd) begin
            if (ctl.cfg && !cfg_read_ok) begin
                data_low  <= 8'h00;
                data_high <= 6'h00;
            end else begin
                data_low  <= flash_rdata[7:0];
                data_high <= flash_rdata[13:8];
            end
        end else if (wr_en) begin
            if (paddr == `OFF_DATA_LOW) begin
                data_low <= pwdata[7:0];
            end
            if (paddr == `OFF_DATA_HIGH) begin
                data_high <= pwdata[5:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_addr <= 15'h0000;
            flash_cfg  <= 1'b0;
        end else begin
            flash_addr <= word_addr;
            flash_cfg  <= ctl.cfg;
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= '0;
        end else begin
            ctl.rd <= 1'b0;
            if (op_end) begin
                ctl.wr    <= 1'b0;
                ctl.error <= 1'b0;
                if (ctl.erase_sel) begin
                    ctl.erase_sel <= 1'b0;
                end
            end
            if (wr_en && paddr == `OFF_CONTROL) begin
                if (!ctl.wr) begin
                    ctl.cfg        <= pwdata[`CTL_CFG];
                    ctl.latch_only <= pwdata[`CTL_LATCH_ONLY];
                    ctl.erase_sel  <= pwdata[`CTL_ERASE];
                    ctl.enable     <= pwdata[`CTL_EN];
                    ctl.error      <= pwdata[`CTL_ERR];
                    ctl.rd         <= pwdata[`CTL_RD];
                end
                if (start_ok) begin
                    ctl.wr <= 1'b1;
                end
                if (wr_attempt) begin
                    ctl.error <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // unlock sequence tracker
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_state <= flash_sw_pkg::KEY_IDLE;
        end else if (wr_attempt) begin
            key_state <= flash_sw_pkg::KEY_IDLE;
        end else if (wr_en && paddr == `OFF_UNLOCK) begin
            case (key_state)
                flash_sw_pkg::KEY_HALF: begin
                    key_state <= pwdata[7:0] == `KEY_SECOND ?
                                 flash_sw_pkg::KEY_OPEN : flash_sw_pkg::KEY_IDLE;
                end
                default: begin
                    key_state <= pwdata[7:0] == `KEY_FIRST ?
                                 flash_sw_pkg::KEY_HALF : flash_sw_pkg::KEY_IDLE;
                end
            endcase
        end else if (wr_en) begin
            key_state <= flash_sw_pkg::KEY_IDLE;
        end
    end

    // ----------------------------------------
    // operation sequencer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt <= 2'h0;
        end else begin
            slot_cnt <= slot_tick ? 2'h0 : slot_cnt + 2'h1;
        end
    end

    always_comb begin
        next_op_state = op_state;
        case (op_state)
            flash_sw_pkg::OP_IDLE: begin
                if (start_ok) begin
                    next_op_state = flash_sw_pkg::OP_NOPS;
                end
            end
            flash_sw_pkg::OP_NOPS: begin
                if (slot_tick && nop_cnt == NOP_W'(`FORCED_NOPS - 1)) begin
                    if (ctl.erase_sel || !ctl.latch_only) begin
                        next_op_state = flash_sw_pkg::OP_TIMED;
                    end else begin
                        next_op_state = flash_sw_pkg::OP_FINISH;
                    end
                end
            end
            flash_sw_pkg::OP_TIMED: begin
                if (timer_done) begin
                    next_op_state = flash_sw_pkg::OP_FINISH;
                end
            end
            flash_sw_pkg::OP_FINISH: next_op_state = flash_sw_pkg::OP_IDLE;
            default:                 next_op_state = flash_sw_pkg::OP_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_state      <= flash_sw_pkg::OP_IDLE;
            nop_cnt       <= '0;
            op_prog       <= 1'b0;
            forced_nop    <= 1'b0;
            cpu_stall     <= 1'b0;
            flash_program <= 1'b0;
            flash_erase   <= 1'b0;
        end else begin
            op_state      <= next_op_state;
            forced_nop    <= next_op_state == flash_sw_pkg::OP_NOPS;
            cpu_stall     <= next_op_state == flash_sw_pkg::OP_TIMED;
            flash_program <= timer_start && !ctl.erase_sel;
            flash_erase   <= timer_start && ctl.erase_sel;
            if (op_state == flash_sw_pkg::OP_IDLE) begin
                nop_cnt <= '0;
                op_prog <= !pwdata[`CTL_ERASE] && !pwdata[`CTL_LATCH_ONLY];
            end else if (op_state == flash_sw_pkg::OP_NOPS && slot_tick) begin
                nop_cnt <= nop_cnt + NOP_W'(1);
            end
        end
    end

    flash_op_timer #(
        .CNT_W (32)
    ) u_timer (
        .clk   (pclk),
        .rst_n (presetn),
        .start (timer_start),
        .load  (ctl.erase_sel ? 32'(ERASE_CYCLES) : 32'(PROG_CYCLES)),
        .busy  (),
        .done  (timer_done)
    );

    // ----------------------------------------
    // write latch row
    // ----------------------------------------
    for (genvar i = 0; i < `ROW_WORDS; i++) begin : g_latch
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                row[i] <= `ERASED_WORD;
            end else if (op_end && op_prog) begin
                row[i] <= `ERASED_WORD;
            end else if (start_ok && !pwdata[`CTL_ERASE] && addr_low[3:0] == 4'(i)) begin
                row[i] <= {data_high, data_low};
            end
        end
        assign flash_row_data[i*`WORD_BITS +: `WORD_BITS] = row[i];
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
            irq_mask   <= 2'h0;
            irq        <= 1'b0;
        end else begin
            if (wr_en && paddr == `OFF_IRQ_MASK) begin
                irq_mask <= pwdata[1:0];
            end
            irq_status <= (irq_status
                           & ~((wr_en && paddr == `OFF_IRQ_STATUS) ? pwdata[1:0] : 2'h0))
                          | {wr_attempt && !start_ok, op_end};
            irq        <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_addr_high_msb;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr == `OFF_ADDR_HIGH |=> prdata[7] && pready;
    endproperty
    a_addr_high_msb: assert property (p_addr_high_msb) else $error("high address msb not one");

    property p_ctl_msb;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable && paddr == `OFF_CONTROL |=> prdata[7] && prdata[6:0] == $past(ctl);
    endproperty
    a_ctl_msb: assert property (p_ctl_msb) else $error("control read wrong");

    property p_read_pulse;
        @(posedge pclk) disable iff (!presetn)
        ctl.rd && !(ctl.cfg && !cfg_read_ok) |=> !ctl.rd && data_low == $past(flash_rdata[7:0]);
    endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read trigger misbehaved");

    property p_cfg_clear;
        @(posedge pclk) disable iff (!presetn)
        ctl.rd && ctl.cfg && !cfg_read_ok |=> data_low == 8'h00 && data_high == 6'h00;
    endproperty
    a_cfg_clear: assert property (p_cfg_clear) else $error("bad config read not cleared");

    property p_err_set;
        @(posedge pclk) disable iff (!presetn)
        wr_attempt |=> ctl.error;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error flag not set");

    property p_locked;
        @(posedge pclk) disable iff (!presetn)
        wr_attempt && key_state != flash_sw_pkg::KEY_OPEN && op_state == flash_sw_pkg::OP_IDLE
        |=> op_state == flash_sw_pkg::OP_IDLE && !ctl.wr && ctl.error;
    endproperty
    a_locked: assert property (p_locked) else $error("locked trigger started");

    property p_disabled;
        @(posedge pclk) disable iff (!presetn)
        wr_attempt && !pwdata[`CTL_EN] |=> !$rose(ctl.wr);
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled trigger started");

    property p_nops;
        @(posedge pclk) disable iff (!presetn)
        $rose(forced_nop) |-> forced_nop[*5] ##[1:4] !forced_nop;
    endproperty
    a_nops: assert property (p_nops) else $error("forced no-op window wrong");

    property p_key_reset;
        @(posedge pclk) disable iff (!presetn)
        wr_attempt |=> key_state == flash_sw_pkg::KEY_IDLE;
    endproperty
    a_key_reset: assert property (p_key_reset) else $error("unlock tracker not reset");

    property p_erase_clear;
        @(posedge pclk) disable iff (!presetn)
        op_end && ctl.erase_sel |=> !ctl.erase_sel && !ctl.wr && ctl.error == $past(wr_attempt);
    endproperty
    a_erase_clear: assert property (p_erase_clear) else $error("erase select not cleared");

    property p_wr_clear;
        @(posedge pclk) disable iff (!presetn)
        op_end |=> !ctl.wr ##1 op_state == flash_sw_pkg::OP_IDLE;
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("write trigger not cleared");

    c_program: cover property (@(posedge pclk) disable iff (!presetn) flash_program);
    c_erase:   cover property (@(posedge pclk) disable iff (!presetn) flash_erase);
    c_latch:   cover property (@(posedge pclk) disable iff (!presetn)
                               op_end && !op_prog && !ctl.erase_sel);

endmodule : flash_self_write

`default_nettype wire

//--- sim/flash_array_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// flash array behind the sequencer
// ----------------------------------------
module flash_array_model (
    input  wire logic         pclk,
    input  wire logic [14:0]  flash_addr,
    input  wire logic         flash_cfg,
    input  wire logic [223:0] flash_row_data,
    input  wire logic         flash_program,
    input  wire logic         flash_erase,
    output logic      [13:0]  flash_rdata
);
    logic [13:0] mem [0:63];
    initial for (int i = 0; i < 64; i++) mem[i] = 14'(i * 3 + 1);
    // whole row of sixteen words at once
    always @(posedge pclk) begin
        for (int i = 0; i < 16; i++) begin
            if (flash_program === 1'b1) mem[{flash_addr[5:4], 4'(i)}] = flash_row_data[i*14+:14];
            if (flash_erase === 1'b1) mem[{flash_addr[5:4], 4'(i)}] = 14'h3fff;
        end
    end
    assign flash_rdata = flash_cfg ? {11'h000, flash_addr[2:0]} : mem[flash_addr[5:0]];
endmodule : flash_array_model
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_sw_map.svh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [14:0] flash_addr;
    logic [13:0] flash_rdata;
    logic [223:0] flash_row_data;
    logic flash_cfg, flash_program, flash_erase, forced_nop, cpu_stall;
    int n_mismatch = 0, tests_run = 0, cyc = 0, n_prog = 0, n_erase = 0, n_nop = 0, n_stall = 0;
    flash_self_write #(.PROG_CYCLES(20), .ERASE_CYCLES(20)) i_flash_self_write (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .flash_addr(flash_addr), .flash_cfg(flash_cfg), .flash_rdata(flash_rdata),
        .flash_row_data(flash_row_data), .flash_program(flash_program),
        .flash_erase(flash_erase), .forced_nop(forced_nop), .cpu_stall(cpu_stall));
    flash_array_model i_flash_array_model (.pclk(pclk), .flash_addr(flash_addr),
        .flash_cfg(flash_cfg), .flash_row_data(flash_row_data),
        .flash_program(flash_program), .flash_erase(flash_erase), .flash_rdata(flash_rdata));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ----------------------------------------
    // monitors and timeout
    // ----------------------------------------
    always @(posedge pclk) begin
        cyc++;
        if (flash_program === 1'b1) n_prog++;
        if (flash_erase === 1'b1) n_erase++;
        if (forced_nop === 1'b1) n_nop++;
        if (cpu_stall === 1'b1) n_stall++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // apb access
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        err_seen = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(r, {24'h000000, e});
    endtask : rc
    task automatic key_and(input logic [7:0] c);
        xfer(1'b1, `OFF_UNLOCK, `KEY_FIRST);
        xfer(1'b1, `OFF_UNLOCK, `KEY_SECOND);
        xfer(1'b1, `OFF_CONTROL, c);
    endtask : key_and
    task automatic wait_idle();
        do begin
            xfer(1'b0, `OFF_CONTROL, 8'h00);
        end while (r[1] !== 1'b0);
    endtask : wait_idle
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(`OFF_ADDR_HIGH, 8'h80);
        rc(`OFF_CONTROL, 8'h80);
        xfer(1'b1, `OFF_ADDR_HIGH, 8'hff);
        rc(`OFF_ADDR_HIGH, 8'hff);
        xfer(1'b1, `OFF_ADDR_HIGH, 8'h00);
        xfer(1'b0, 12'h020, 8'h00);
        chk(32'(err_seen), 32'h1);
        $display("test registers done");
        xfer(1'b1, `OFF_ADDR_LOW, 8'h05);
        xfer(1'b1, `OFF_CONTROL, 8'h01);
        rc(`OFF_DATA_LOW, 8'h10);
        rc(`OFF_CONTROL, 8'h80);
        xfer(1'b1, `OFF_CONTROL, 8'h40);
        xfer(1'b1, `OFF_CONTROL, 8'h41);
        rc(`OFF_DATA_LOW, 8'h00);
        xfer(1'b1, `OFF_ADDR_LOW, 8'h06);
        xfer(1'b1, `OFF_CONTROL, 8'h41);
        rc(`OFF_DATA_LOW, 8'h06);
        xfer(1'b1, `OFF_CONTROL, 8'h00);
        $display("test reads done");
        xfer(1'b1, `OFF_CONTROL, 8'h06);
        rc(`OFF_CONTROL, 8'h8c);
        rc(`OFF_IRQ_STATUS, 8'h02);
        chk(32'(irq), 32'h0);
        xfer(1'b1, `OFF_IRQ_MASK, 8'h03);
        @(posedge pclk);
        chk(32'(irq), 32'h1);
        xfer(1'b1, `OFF_IRQ_STATUS, 8'h03);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        $display("test locked trigger done");
        xfer(1'b1, `OFF_ADDR_LOW, 8'h10);
        xfer(1'b1, `OFF_DATA_LOW, 8'h5a);
        xfer(1'b1, `OFF_DATA_HIGH, 8'h21);
        key_and(8'h06);
        wait_idle();
        chk(n_prog, 1);
        chk(n_stall, 20 + 1);
        chk(32'(n_nop >= 5 && n_nop <= 8), 32'h1);
        rc(`OFF_CONTROL, 8'h84);
        xfer(1'b1, `OFF_CONTROL, 8'h05);
        rc(`OFF_DATA_HIGH, 8'h21);
        xfer(1'b1, `OFF_ADDR_LOW, 8'h11);
        xfer(1'b1, `OFF_CONTROL, 8'h05);
        rc(`OFF_DATA_HIGH, 8'h3f);
        $display("test program done");
        key_and(8'h26);
        wait_idle();
        chk(n_prog, 1);
        key_and(8'h36);
        wait_idle();
        chk(n_erase, 1);
        chk(n_prog, 1);
        rc(`OFF_CONTROL, 8'ha4);
        xfer(1'b1, `OFF_CONTROL, 8'h00);
        key_and(8'h02);
        rc(`OFF_CONTROL, 8'h88);
        xfer(1'b1, `OFF_CONTROL, 8'h04);
        xfer(1'b1, `OFF_UNLOCK, `KEY_FIRST);
        xfer(1'b1, `OFF_UNLOCK, 8'h11);
        xfer(1'b1, `OFF_UNLOCK, `KEY_SECOND);
        xfer(1'b1, `OFF_CONTROL, 8'h06);
        rc(`OFF_CONTROL, 8'h8c);
        chk(n_prog + n_erase, 2);
        $display("test refused triggers done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
